// ### src/rwi_cfg.svh
`ifndef RWI_CFG_SVH
`define RWI_CFG_SVH

// Program counter vectors.
`define RWI_RESET_VEC 21'h000000
`define RWI_HI_VEC 21'h000008
`define RWI_LO_VEC 21'h000018

// Port A reset values and the mask that hides bits 7 and 6.
`define RWI_DIR_RST 8'hFF
`define RWI_LAT_POR 8'h00
`define RWI_PA_LOW_MASK 8'h3F

// Interrupt flags: bit 7 is unimplemented and reads as zero.
`define RWI_FLAG_IMPL 8'h7F
`define RWI_FLAG_RST 8'h00

// Hardware stack pointer limits.
`define RWI_SP_RST 5'h00
`define RWI_SP_MAX 5'h1F

// Bit positions of the upper and high top-of-stack bytes.
`define RWI_TOS_UPPER_LSB 16
`define RWI_TOS_HIGH_LSB 8

`endif

// ### src/rwi_pkg.sv
package rwi_pkg;

    // Core run state.
    typedef enum logic [0:0] {
        RWI_RUN = 1'b0,
        RWI_SLEEP = 1'b1
    } rwi_mode_e;

    // Cause of the most recent reset.
    typedef enum logic [2:0] {
        RWI_CAUSE_POR = 3'b000,
        RWI_CAUSE_BOR = 3'b001,
        RWI_CAUSE_PIN = 3'b010,
        RWI_CAUSE_WDT = 3'b011,
        RWI_CAUSE_INSTR = 3'b100,
        RWI_CAUSE_STACK = 3'b101
    } rwi_cause_e;

    // Whole state of the controller.
    typedef struct packed {
        rwi_mode_e mode;
        logic [20:0] pc;
        logic [20:0] tos;
        logic [4:0] sp;
        logic stack_full;
        logic [7:0] pa_in;
        logic [7:0] pa_lat;
        logic [7:0] pa_dir;
        logic [7:0] flags;
        rwi_cause_e cause;
    } rwi_state_s;

endpackage

// ### src/rwi_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwi_cfg.svh"

// Contract
// - Interrupt wake with enable pushes PC to top-of-stack.
// - Same wake advances hardware stack pointer; at 1Fh it stays and sets stack full.
// - Same wake loads vector 0008h high, 0018h low.
// - Wake caused by an enabled flag or the watchdog wake; a flag is left set.
// - Unimplemented bits always read as zero.
// - Port A bits 7:6 exist only when freed.
// - Unchanged bits keep value through reset or wake.
// - Condition-dependent bits follow the reset cause.
// - Every device reset sends PC to 0000h.
module rwi_core
    import rwi_pkg::*;
(
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic reset,
    // Other reset sources.
    input wire logic dev_rst_req,
    input wire rwi_cause_e dev_rst_cause,
    // Core activity.
    input wire logic pc_step,
    input wire logic sleep_req,
    input wire logic wdt_wake,
    // Interrupt control.
    input wire logic high_prio_global_irq_enable,
    input wire logic low_prio_global_irq_enable,
    input wire logic [7:0] irq_enable,
    input wire logic [7:0] irq_high_prio,
    input wire logic [7:0] irq_flag_set,
    input wire logic [7:0] irq_flag_clr,
    // Port A.
    input wire logic osc_frees_ra67,
    input wire logic [7:0] port_a_pins,
    input wire logic latch_wr,
    input wire logic [7:0] latch_wdata,
    input wire logic dir_wr,
    input wire logic [7:0] dir_wdata,
    // State seen by software.
    output logic asleep,
    output logic [20:0] pc,
    output logic [7:0] stack_top_upper,
    output logic [7:0] stack_top_high,
    output logic [7:0] stack_top_low,
    output logic [4:0] hw_stack_pointer,
    output logic stack_full,
    output logic [7:0] periph_irq_flag_regs,
    output logic [7:0] port_a_input,
    output logic [7:0] port_a_latch,
    output logic [7:0] port_a_direction,
    output rwi_cause_e reset_cause
);

    localparam rwi_state_s RST_STATE = '{
        mode: RWI_RUN,
        pc: `RWI_RESET_VEC,
        tos: 21'h000000,
        sp: `RWI_SP_RST,
        stack_full: 1'b0,
        pa_in: 8'h00,
        pa_lat: `RWI_LAT_POR,
        pa_dir: `RWI_DIR_RST,
        flags: `RWI_FLAG_RST,
        cause: RWI_CAUSE_POR
    };

    rwi_state_s s_q;
    rwi_state_s s_d;
    rwi_state_s rst_val;
    logic [7:0] pa_mask;
    logic [7:0] flags_live;
    logic hi_pend;
    logic lo_pend;
    logic irq_wake;
    logic full_reset;

    // Next-state logic; reset sources override wake, wake overrides run.
    always_comb begin
        s_d = s_q;
        pa_mask = osc_frees_ra67 ? 8'hFF : `RWI_PA_LOW_MASK;
        // Hidden port bits must read zero from the very first reset edge, not one cycle later.
        rst_val = RST_STATE;
        rst_val.pa_dir = `RWI_DIR_RST & pa_mask;
        // Set wins over clear so a flag raised while software clears it is kept.
        flags_live = ((s_q.flags & ~irq_flag_clr) | irq_flag_set) & `RWI_FLAG_IMPL;
        hi_pend = |(s_q.flags & irq_enable & irq_high_prio);
        lo_pend = |(s_q.flags & irq_enable & ~irq_high_prio);
        irq_wake = hi_pend | lo_pend;
        full_reset = (dev_rst_cause == RWI_CAUSE_POR) || (dev_rst_cause == RWI_CAUSE_BOR);
        s_d.flags = flags_live;
        s_d.pa_in = port_a_pins & pa_mask;
        if (latch_wr) begin
            s_d.pa_lat = latch_wdata;
        end
        if (dir_wr) begin
            s_d.pa_dir = dir_wdata;
        end
        unique case (s_q.mode)
            RWI_RUN: begin
                if (sleep_req) begin
                    s_d.mode = RWI_SLEEP;
                end else if (pc_step) begin
                    s_d.pc = 21'(s_q.pc + 21'h000001);
                end
            end
            RWI_SLEEP: begin
                // Flags are left as they are so software can see the wake source.
                if (irq_wake) begin
                    s_d.mode = RWI_RUN;
                    if ((hi_pend && high_prio_global_irq_enable) ||
                        (lo_pend && low_prio_global_irq_enable)) begin
                        s_d.tos = s_q.pc;
                        // The pointer saturates; the full flag tells software it was lost.
                        if (s_q.sp == `RWI_SP_MAX) begin
                            s_d.stack_full = 1'b1;
                        end else begin
                            s_d.sp = 5'(s_q.sp + 5'h01);
                        end
                        if (hi_pend && high_prio_global_irq_enable) begin
                            s_d.pc = `RWI_HI_VEC;
                        end else begin
                            s_d.pc = `RWI_LO_VEC;
                        end
                    end
                end else if (wdt_wake) begin
                    s_d.mode = RWI_RUN;
                end
            end
        endcase
        if (dev_rst_req) begin
            s_d.mode = RWI_RUN;
            s_d.pc = `RWI_RESET_VEC;
            s_d.sp = `RWI_SP_RST;
            s_d.stack_full = 1'b0;
            s_d.pa_dir = `RWI_DIR_RST;
            s_d.flags = `RWI_FLAG_RST;
            s_d.cause = dev_rst_cause;
            // Latch survives all but power and brown-out resets.
            s_d.pa_lat = full_reset ? `RWI_LAT_POR : s_q.pa_lat;
        end
        // Masking after all writes keeps hidden port bits at zero.
        s_d.pa_lat = s_d.pa_lat & pa_mask;
        s_d.pa_dir = s_d.pa_dir & pa_mask;
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= rst_val;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign asleep = (s_q.mode == RWI_SLEEP);
    assign pc = s_q.pc;
    assign stack_top_upper = {3'h0, s_q.tos[20:`RWI_TOS_UPPER_LSB]};
    assign stack_top_high = s_q.tos[15:`RWI_TOS_HIGH_LSB];
    assign stack_top_low = s_q.tos[7:0];
    assign hw_stack_pointer = s_q.sp;
    assign stack_full = s_q.stack_full;
    assign periph_irq_flag_regs = s_q.flags;
    assign port_a_input = s_q.pa_in;
    assign port_a_latch = s_q.pa_lat;
    assign port_a_direction = s_q.pa_dir;
    assign reset_cause = s_q.cause;

    hi_vector_a: assert property (@(posedge mclk) disable iff (reset)
        (s_q.mode == RWI_SLEEP && hi_pend && high_prio_global_irq_enable && !dev_rst_req)
        |=> (pc == `RWI_HI_VEC && !asleep))
        else $error("High priority wake did not load the high vector.");

    lo_vector_a: assert property (@(posedge mclk) disable iff (reset)
        (s_q.mode == RWI_SLEEP && !hi_pend && lo_pend && low_prio_global_irq_enable
         && !dev_rst_req) |=> (pc == `RWI_LO_VEC))
        else $error("Low priority wake did not load the low vector.");

    tos_push_a: assert property (@(posedge mclk) disable iff (reset)
        (s_q.mode == RWI_SLEEP && irq_wake && !dev_rst_req &&
         ((hi_pend && high_prio_global_irq_enable) || (lo_pend && low_prio_global_irq_enable)))
        |=> ({stack_top_upper[4:0], stack_top_high, stack_top_low} == $past(pc)))
        else $error("Top of stack does not hold the pre-wake program counter.");

    sp_advance_a: assert property (@(posedge mclk) disable iff (reset)
        (asleep && irq_wake && !dev_rst_req && hw_stack_pointer != `RWI_SP_MAX &&
         ((hi_pend && high_prio_global_irq_enable) || (lo_pend && low_prio_global_irq_enable)))
        |=> (hw_stack_pointer == 5'($past(hw_stack_pointer) + 5'h01)))
        else $error("Stack pointer did not advance on interrupt wake.");

    wake_flag_a: assert property (@(posedge mclk) disable iff (reset)
        (asleep && !dev_rst_req ##1 !asleep) |-> ($past(irq_wake) || $past(wdt_wake)))
        else $error("Left sleep with no flag and no watchdog wake.");

    reset_vec_a: assert property (@(posedge mclk) disable iff (reset)
        dev_rst_req |=> (pc == `RWI_RESET_VEC && port_a_direction == ($past(pa_mask))
                        && hw_stack_pointer == `RWI_SP_RST))
        else $error("Device reset did not restore vector, direction or pointer.");

    latch_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (dev_rst_req && !full_reset && osc_frees_ra67) |=> $stable(port_a_latch))
        else $error("Latch changed across a warm reset.");

    cause_rec_a: assert property (@(posedge mclk) disable iff (reset)
        dev_rst_req |=> (reset_cause == $past(dev_rst_cause)))
        else $error("Reset cause not recorded.");

    ra_hidden_a: assert property (@(posedge mclk) disable iff (reset)
        !osc_frees_ra67 |=> ({port_a_input[7:6], port_a_latch[7:6], port_a_direction[7:6]}
                           == 6'h00))
        else $error("Port A bits 7:6 visible while not freed.");

    unimpl_zero_a: assert property (@(posedge mclk) disable iff (reset)
        ##1 (periph_irq_flag_regs[7] == 1'b0 && stack_top_upper[7:5] == 3'h0))
        else $error("Unimplemented bit read as one.");

    set_wins_a: assert property (@(posedge mclk) disable iff (reset)
        (irq_flag_set[0] && irq_flag_clr[0] && !dev_rst_req) |=> periph_irq_flag_regs[0])
        else $error("Flag set lost against a clear.");

endmodule

`default_nettype wire

// ### bench/reset_wakeup_register_init_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwi_cfg.svh"

// Self-checking bench for the reset and wake-up core; all stimulus is directed.
module reset_wakeup_register_init_tb
    import rwi_pkg::*;
;
    logic mclk, reset, rst_req, step, slp, wdt, gh, gl, osc, lw, dw, asleep, sfull;
    logic [7:0] ien, ipri, fset, fclr, pins, lwd, dwd, tu, th, tl, flags, pin_q, lat_q, dir_q;
    logic [20:0] pc;
    logic [4:0] sp;
    rwi_cause_e cause_in, cause_q;
    int failures, total_checks;

    rwi_core dut (.mclk(mclk), .reset(reset), .dev_rst_req(rst_req), .dev_rst_cause(cause_in),
        .pc_step(step), .sleep_req(slp), .wdt_wake(wdt), .high_prio_global_irq_enable(gh),
        .low_prio_global_irq_enable(gl), .irq_enable(ien), .irq_high_prio(ipri),
        .irq_flag_set(fset), .irq_flag_clr(fclr), .osc_frees_ra67(osc), .port_a_pins(pins),
        .latch_wr(lw), .latch_wdata(lwd), .dir_wr(dw), .dir_wdata(dwd), .asleep(asleep),
        .pc(pc), .stack_top_upper(tu), .stack_top_high(th), .stack_top_low(tl),
        .hw_stack_pointer(sp), .stack_full(sfull), .periph_irq_flag_regs(flags),
        .port_a_input(pin_q), .port_a_latch(lat_q), .port_a_direction(dir_q),
        .reset_cause(cause_q));

    // One compare for every kind of value; narrower values are zero-extended.
    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Steps the program counter for n edges.
    task automatic run(input int n);
        @(posedge mclk) step <= 1'b1;
        repeat (n) @(posedge mclk);
        step <= 1'b0;
    endtask

    // Sleeps, raises flags or the watchdog wake, and lands after the wake edge.
    task automatic sleep_wake(input logic [7:0] f, input logic w);
        @(posedge mclk) slp <= 1'b1;
        @(posedge mclk) slp <= 1'b0;
        fset <= f;
        wdt <= w;
        @(posedge mclk) fset <= 8'h00;
        wdt <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic t_reset;
        @(negedge mclk);
        check(pc, `RWI_RESET_VEC);
        check(dir_q, `RWI_DIR_RST & `RWI_PA_LOW_MASK);
        check(lat_q, `RWI_LAT_POR);
        check(flags, `RWI_FLAG_RST);
        check(sp, `RWI_SP_RST);
        check(sfull, 1'b0);
        check(cause_q, RWI_CAUSE_POR);
        $display("test reset done");
    endtask

    // High wake first, then a low wake whose flag also tries the dead bit 7.
    task automatic t_wake;
        run(5);
        sleep_wake(8'h01, 1'b0);
        check(asleep, 1'b0);
        check(pc, `RWI_HI_VEC);
        check({tu[4:0], th, tl}, 21'h000005);
        check(tu[7:5], 3'h0);
        check(sp, 5'h01);
        check(flags, 8'h01);
        @(posedge mclk) fclr <= 8'h01;
        gh <= 1'b0;
        @(posedge mclk) fclr <= 8'h00;
        run(3);
        sleep_wake(8'h82, 1'b0);
        check(pc, `RWI_LO_VEC);
        check({tu[4:0], th, tl}, 21'h00000B);
        check(sp, 5'h02);
        check(flags, 8'h02);
        $display("test wake done");
    endtask

    // Wakes with both global enables off must leave the stack and pc alone.
    task automatic t_nogie;
        @(posedge mclk) fclr <= 8'hFF;
        gl <= 1'b0;
        @(posedge mclk) fclr <= 8'h00;
        sleep_wake(8'h00, 1'b1);
        check(asleep, 1'b0);
        check(pc, `RWI_LO_VEC);
        sleep_wake(8'h04, 1'b0);
        check(asleep, 1'b0);
        check(sp, 5'h02);
        check(flags, 8'h04);
        $display("test no-enable wake done");
    endtask

    task automatic t_port_a_input;
        @(posedge mclk) lw <= 1'b1;
        lwd <= 8'hA5;
        dw <= 1'b1;
        dwd <= 8'hC3;
        pins <= 8'hFF;
        @(posedge mclk) lw <= 1'b0;
        dw <= 1'b0;
        @(negedge mclk);
        check(lat_q, 8'h25);
        check(dir_q, 8'h03);
        check(pin_q, 8'h3F);
        @(posedge mclk) osc <= 1'b1;
        lw <= 1'b1;
        @(posedge mclk) lw <= 1'b0;
        @(negedge mclk);
        check(lat_q, 8'hA5);
        check(pin_q, 8'hFF);
        // Taking the pins back must hide the latch bits written while they were free.
        @(posedge mclk) osc <= 1'b0;
        @(posedge mclk) osc <= 1'b1;
        @(negedge mclk);
        check(lat_q, 8'h25);
        check(pin_q, 8'h3F);
        $display("test port done");
    endtask

    // Every reset cause in turn; only power-on and brown-out clear the latch.
    task automatic t_devrst;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk) lw <= 1'b1;
            @(posedge mclk) lw <= 1'b0;
            rst_req <= 1'b1;
            cause_in <= rwi_cause_e'(i[2:0]);
            @(posedge mclk) rst_req <= 1'b0;
            @(negedge mclk);
            check(cause_q, i[2:0]);
            check(lat_q, (i < 2) ? 8'h00 : 8'hA5);
            check(pc, `RWI_RESET_VEC);
            check(dir_q, `RWI_DIR_RST);
            check(sp, `RWI_SP_RST);
        end
        $display("test device reset done");
    endtask

    // A set and a clear meet on one flag, then the stack is filled past its top.
    task automatic t_stack;
        @(posedge mclk) fclr <= 8'hFF;
        gh <= 1'b1;
        @(posedge mclk) fclr <= 8'h01;
        fset <= 8'h01;
        @(posedge mclk) fclr <= 8'h00;
        fset <= 8'h00;
        @(negedge mclk);
        check(flags, 8'h01);
        // The last push finds the pointer at its top and is lost.
        for (int i = 1; i <= 32; i++) begin
            sleep_wake(8'h00, 1'b0);
            check(sp, (i < 32) ? 21'(i) : 21'h00001F);
            check(sfull, (i == 32) ? 1'b1 : 1'b0);
        end
        check(pc, `RWI_HI_VEC);
        check({tu[4:0], th, tl}, 21'h000008);
        @(posedge mclk) rst_req <= 1'b1;
        cause_in <= RWI_CAUSE_PIN;
        @(posedge mclk) rst_req <= 1'b0;
        @(negedge mclk);
        check(sfull, 1'b0);
        check(sp, `RWI_SP_RST);
        check(flags, `RWI_FLAG_RST);
        check(pc, `RWI_RESET_VEC);
        $display("test stack done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Free-running 10 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Bounds the whole run so a hang still reaches the verdict.
    initial begin
        #2000000;
        failures++;
        finish_test;
    end

    // Main sequence; reset is held for 20 edges before any request.
    initial begin
        {reset, rst_req, step, slp, wdt, gh, gl, osc, lw, dw} = 10'b1000011000;
        {fset, fclr, pins, lwd, dwd} = '0;
        ien = 8'h07;
        ipri = 8'h01;
        cause_in = RWI_CAUSE_PIN;
        failures = 0;
        total_checks = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_reset;
        t_wake;
        t_nogie;
        t_port_a_input;
        t_devrst;
        t_stack;
        finish_test;
    end
endmodule
`default_nettype wire
